// ==== shared/sld_pkg.sv ====
// constants and types of the lane deskew monitor and link initializer
// assumes a 40 MHz core clock and a 32-bit APB register port
// Functional notes
// [R1] only a four-lane capable port contains the single lane deskew monitor
// [R2] each column is full marker, partial marker, or markerless
// [R3] one isolated bit error never changes the lane alignment
// [R4] hunt clears count and lock; leaves on all lanes locked plus full column
// [R5] confirm reaches hold after four full columns; a partial returns to hunt
// [R6] hold sets deskew_locked, clears misalign count; partial goes to recheck
// [R7] recheck returns to hold after four fulls; second partial unlocks to hunt
// [R8] single-lane initializer starts quiet, driver off, until quiet_timer expires
// [R9] partner_search drives idle; lane_locked enters narrow_link_up
// [R10] restart_request restarts initialization from any state
// [R11] single-lane link_up is true only in narrow_link_up
// [R12] idle while link down; offered symbols and packets sent while up
// [R13] idle fills the link whenever nothing else is sent
// [R14] dual-width port starts quiet with all four drivers off
// [R15] search drives lanes 0 and 2; lock on lane 0 or 2 enters width_probe
// [R16] width_probe enables lanes 1 and 3 and starts probe_timer
// [R17] deskew locked without single override enters wide_link_up until lost
// [R18] probe expiry without deskew or with override picks a single-lane state
// [R19] primary lane locked without alternate override enters narrow_up_primary
// [R20] alternate override or only lane 2 locked enters narrow_up_alternate
// [R21] dual-width link_up true only in the three link-up states
// [R22] quiet_timer expires after 120 us of continuous enable, resets otherwise
// [R23] probe_timer expires after 12 ms of continuous enable, resets otherwise
// [R24] every_lane_locked is the AND of the four lane lock flags
// [R25] alternate_input_select marks lane 2 input in single-lane operation
// [R26] reset gives hunt, quiet phase, drivers off, link down
// [R27] leaving any link-up state returns to quiet phase
package sld_pkg;
  localparam int CLK_MHZ = 40;
  localparam int QUIET_US = 120;
  localparam int QUIET_CYC = QUIET_US * CLK_MHZ;
  localparam int PROBE_MS = 12;
  localparam int PROBE_CYC = PROBE_MS * 1000 * CLK_MHZ;
  localparam int MARKER_RUN = 4;
  localparam int LANES = 4;

  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam int CTRL_RESTART_BIT = 0;
  localparam int CTRL_SINGLE_BIT = 1;
  localparam int CTRL_ALT_BIT = 2;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int ST_LINK_UP_BIT = 0;
  localparam int ST_WIDE_BIT = 1;
  localparam int ST_ALT_SEL_BIT = 2;
  localparam int ST_DESKEW_BIT = 3;
  localparam int ST_ALL_LOCK_BIT = 4;
  localparam int ST_INIT_LSB = 8;
  localparam int ST_DESKEW_LSB = 16;

  typedef enum logic [3:0] {
    DSK_HUNT = 4'h1,
    DSK_CONFIRM = 4'h2,
    DSK_HOLD = 4'h4,
    DSK_RECHECK = 4'h8
  } sld_dsk_state_t;

  typedef enum logic [6:0] {
    INI_QUIET = 7'h01,
    INI_SEARCH = 7'h02,
    INI_PROBE = 7'h04,
    INI_NARROW = 7'h08,
    INI_WIDE = 7'h10,
    INI_UP_PRI = 7'h20,
    INI_UP_ALT = 7'h40
  } sld_ini_state_t;

  typedef struct packed {
    logic alt_lane_override;
    logic single_lane_override;
  } sld_ctrl_t;

  typedef struct packed {
    logic valid;
    logic [LANES-1:0] marker;
  } sld_col_t;
endpackage

// ==== hdl/sld_link_init.sv ====
// lane deskew monitor, link initializer, transmit gate and APB registers
// assumes lane lock flags and marker columns come from the lane synchronizers,
// all inputs synchronous to clk
`timescale 1ns/1ps
module sld_link_init #(
  parameter bit WIDE_CAPABLE = 1'b1,
  parameter int unsigned QUIET_CYCLES = sld_pkg::QUIET_CYC,
  parameter int unsigned PROBE_CYCLES = sld_pkg::PROBE_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [sld_pkg::LANES-1:0] lane_locked,
  input wire sld_pkg::sld_col_t rx_col,
  input wire logic tx_offer,
  output logic tx_take,
  output logic tx_fill_idle,
  output logic [sld_pkg::LANES-1:0] lane_drv_oe,
  output logic link_up,
  output logic wide_mode,
  output logic alternate_input_select,
  output logic deskew_locked
);
  localparam int QW = $clog2(QUIET_CYCLES + 1);
  localparam int PW = $clog2(PROBE_CYCLES + 1);

  // ---------------- register port ----------------
  sld_pkg::sld_ctrl_t ctrl_r, ctrl_nxt;
  logic restart_r, restart_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] status_w;
  logic mapped_w;
  logic every_lane_locked;
  sld_pkg::sld_dsk_state_t dsk_r;
  sld_pkg::sld_ini_state_t ini_r, ini_nxt;
  logic link_up_r, wide_r, alt_sel_r, locked_w;

  always_comb begin
    mapped_w = (paddr == sld_pkg::CTRL_OFS) || (paddr == sld_pkg::STATUS_OFS);
    status_w = 32'h0;
    status_w[sld_pkg::ST_LINK_UP_BIT] = link_up_r;
    status_w[sld_pkg::ST_WIDE_BIT] = wide_r;
    status_w[sld_pkg::ST_ALT_SEL_BIT] = alt_sel_r;
    status_w[sld_pkg::ST_DESKEW_BIT] = locked_w;
    status_w[sld_pkg::ST_ALL_LOCK_BIT] = every_lane_locked;
    status_w[sld_pkg::ST_INIT_LSB +: 7] = ini_r;
    status_w[sld_pkg::ST_DESKEW_LSB +: 4] = dsk_r;
    ctrl_nxt = ctrl_r;
    restart_nxt = 1'b0;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    // setup cycle prepares the answer, access cycle finds pready high
    pready_nxt = psel && !penable;
    if (psel && !penable) begin
      pslverr_nxt = !mapped_w;
      prdata_nxt = 32'h0;
      if (!pwrite && paddr == sld_pkg::CTRL_OFS) begin
        prdata_nxt[sld_pkg::CTRL_SINGLE_BIT] = ctrl_r.single_lane_override;
        prdata_nxt[sld_pkg::CTRL_ALT_BIT] = ctrl_r.alt_lane_override;
      end else if (!pwrite && paddr == sld_pkg::STATUS_OFS) begin
        prdata_nxt = status_w;
      end
    end
    if (psel && penable && pready_r && pwrite && paddr == sld_pkg::CTRL_OFS && pstrb[0]) begin
      ctrl_nxt.single_lane_override = pwdata[sld_pkg::CTRL_SINGLE_BIT];
      ctrl_nxt.alt_lane_override = pwdata[sld_pkg::CTRL_ALT_BIT];
      restart_nxt = pwdata[sld_pkg::CTRL_RESTART_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r <= sld_pkg::CTRL_RESET;
      restart_r <= 1'b0;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      restart_r <= restart_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // [R24] all four lanes locked
  assign every_lane_locked = &lane_locked;

  // ---------------- deskew monitor ----------------
  // [R1] present only in a four-lane capable port
  generate
    if (WIDE_CAPABLE) begin : g_deskew
      sld_pkg::sld_dsk_state_t dsk_nxt;
      logic [2:0] marker_column_count_r, marker_column_count_nxt;
      logic [2:0] misalign_count_r, misalign_count_nxt;
      logic deskew_locked_r, deskew_locked_nxt;
      logic full_col, part_col;

      always_comb begin
        // [R2] full, partial or markerless column
        full_col = rx_col.valid && (&rx_col.marker);
        part_col = rx_col.valid && (|rx_col.marker) && !(&rx_col.marker);
        dsk_nxt = dsk_r;
        marker_column_count_nxt = marker_column_count_r;
        misalign_count_nxt = misalign_count_r;
        deskew_locked_nxt = deskew_locked_r;
        unique case (dsk_r)
          sld_pkg::DSK_HUNT: begin
            // [R4] hunt clears and waits
            marker_column_count_nxt = 3'h0;
            deskew_locked_nxt = 1'b0;
            if (every_lane_locked && full_col) begin
              dsk_nxt = sld_pkg::DSK_CONFIRM;
            end
          end
          sld_pkg::DSK_CONFIRM: begin
            // [R5] four clean full columns
            if (part_col) begin
              dsk_nxt = sld_pkg::DSK_HUNT;
            end else if (full_col) begin
              marker_column_count_nxt = marker_column_count_r + 3'h1;
              if (marker_column_count_r == 3'(sld_pkg::MARKER_RUN - 1)) begin
                dsk_nxt = sld_pkg::DSK_HOLD;
              end
            end
          end
          sld_pkg::DSK_HOLD: begin
            // [R6] locked, watch for partial columns
            deskew_locked_nxt = 1'b1;
            misalign_count_nxt = 3'h0;
            marker_column_count_nxt = 3'h0;
            if (part_col) begin
              misalign_count_nxt = 3'h1;
              dsk_nxt = sld_pkg::DSK_RECHECK;
            end
          end
          sld_pkg::DSK_RECHECK: begin
            // [R3] one partial column keeps the alignment and the lock
            // [R7] second partial unlocks, four fulls restore
            if (part_col) begin
              misalign_count_nxt = misalign_count_r + 3'h1;
              deskew_locked_nxt = 1'b0;
              dsk_nxt = sld_pkg::DSK_HUNT;
            end else if (full_col) begin
              marker_column_count_nxt = marker_column_count_r + 3'h1;
              if (marker_column_count_r == 3'(sld_pkg::MARKER_RUN - 1)) begin
                dsk_nxt = sld_pkg::DSK_HOLD;
              end
            end
          end
          default: begin
            dsk_nxt = sld_pkg::DSK_HUNT;
          end
        endcase
        // losing any lane lock ends the alignment at once
        if (!every_lane_locked) begin
          dsk_nxt = sld_pkg::DSK_HUNT;
          deskew_locked_nxt = 1'b0;
        end
      end

      always_ff @(posedge clk) begin
        if (reset) begin
          // [R26] start in hunt
          dsk_r <= sld_pkg::DSK_HUNT;
          marker_column_count_r <= 3'h0;
          misalign_count_r <= 3'h0;
          deskew_locked_r <= 1'b0;
        end else begin
          dsk_r <= dsk_nxt;
          marker_column_count_r <= marker_column_count_nxt;
          misalign_count_r <= misalign_count_nxt;
          deskew_locked_r <= deskew_locked_nxt;
        end
      end

      assign locked_w = deskew_locked_r;
    end else begin : g_no_deskew
      assign locked_w = 1'b0;
      assign dsk_r = sld_pkg::DSK_HUNT;
    end
  endgenerate

  assign deskew_locked = locked_w;

  // ---------------- timers ----------------
  logic [QW-1:0] quiet_cnt_r, quiet_cnt_nxt;
  logic [PW-1:0] probe_cnt_r, probe_cnt_nxt;
  logic quiet_done, probe_done;

  always_comb begin
    quiet_done = (quiet_cnt_r == QW'(QUIET_CYCLES));
    probe_done = (probe_cnt_r == PW'(PROBE_CYCLES));
    // [R22] quiet timer runs only while in quiet phase
    if (ini_r != sld_pkg::INI_QUIET || restart_r) begin
      quiet_cnt_nxt = '0;
    end else if (quiet_done) begin
      quiet_cnt_nxt = quiet_cnt_r;
    end else begin
      quiet_cnt_nxt = quiet_cnt_r + QW'(1);
    end
    // [R23] probe timer runs only while probing
    if (ini_r != sld_pkg::INI_PROBE || restart_r) begin
      probe_cnt_nxt = '0;
    end else if (probe_done) begin
      probe_cnt_nxt = probe_cnt_r;
    end else begin
      probe_cnt_nxt = probe_cnt_r + PW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      quiet_cnt_r <= '0;
      probe_cnt_r <= '0;
    end else begin
      quiet_cnt_r <= quiet_cnt_nxt;
      probe_cnt_r <= probe_cnt_nxt;
    end
  end

  // ---------------- initializer ----------------
  logic [sld_pkg::LANES-1:0] oe_r, oe_nxt;
  logic link_up_nxt, wide_nxt, alt_sel_nxt;
  logic take_r, take_nxt, idle_r, idle_nxt;

  always_comb begin
    ini_nxt = ini_r;
    unique case (ini_r)
      sld_pkg::INI_QUIET: begin
        // [R8] [R14] silent until quiet timer expiry
        if (quiet_done) begin
          ini_nxt = sld_pkg::INI_SEARCH;
        end
      end
      sld_pkg::INI_SEARCH: begin
        if (!WIDE_CAPABLE) begin
          // [R9] partner found on the only lane
          if (lane_locked[0]) begin
            ini_nxt = sld_pkg::INI_NARROW;
          end
        end else if (lane_locked[0] || lane_locked[2]) begin
          // [R15] partner found on lane 0 or 2
          ini_nxt = sld_pkg::INI_PROBE;
        end
      end
      sld_pkg::INI_PROBE: begin
        if (locked_w && !ctrl_r.single_lane_override) begin
          // [R17] four-lane link
          ini_nxt = sld_pkg::INI_WIDE;
        end else if (probe_done) begin
          // [R18] [R19] [R20] choose the single inbound lane
          if (lane_locked[0] && !ctrl_r.alt_lane_override) begin
            ini_nxt = sld_pkg::INI_UP_PRI;
          end else if (ctrl_r.alt_lane_override || lane_locked[2]) begin
            ini_nxt = sld_pkg::INI_UP_ALT;
          end
        end
      end
      // [R27] lost lock returns to quiet phase
      sld_pkg::INI_NARROW: begin
        if (!lane_locked[0]) begin
          ini_nxt = sld_pkg::INI_QUIET;
        end
      end
      sld_pkg::INI_WIDE: begin
        if (!locked_w) begin
          ini_nxt = sld_pkg::INI_QUIET;
        end
      end
      sld_pkg::INI_UP_PRI: begin
        if (!lane_locked[0]) begin
          ini_nxt = sld_pkg::INI_QUIET;
        end
      end
      sld_pkg::INI_UP_ALT: begin
        if (!lane_locked[2]) begin
          ini_nxt = sld_pkg::INI_QUIET;
        end
      end
      default: begin
        ini_nxt = sld_pkg::INI_QUIET;
      end
    endcase
    // [R10] restart wins over every state
    if (restart_r) begin
      ini_nxt = sld_pkg::INI_QUIET;
    end
    // drivers follow the next state so they change with it
    oe_nxt = '0;
    if (ini_nxt != sld_pkg::INI_QUIET) begin
      oe_nxt[0] = 1'b1;
      if (WIDE_CAPABLE) begin
        oe_nxt[2] = 1'b1;
        // [R16] lanes 1 and 3 on once probing
        if (ini_nxt != sld_pkg::INI_SEARCH) begin
          oe_nxt[1] = 1'b1;
          oe_nxt[3] = 1'b1;
        end
      end
    end
    // [R11] [R21] link up only in link-up states
    link_up_nxt = (ini_nxt == sld_pkg::INI_NARROW) || (ini_nxt == sld_pkg::INI_WIDE) ||
                  (ini_nxt == sld_pkg::INI_UP_PRI) || (ini_nxt == sld_pkg::INI_UP_ALT);
    wide_nxt = (ini_nxt == sld_pkg::INI_WIDE);
    // [R25] lane 2 selected as input
    alt_sel_nxt = (ini_nxt == sld_pkg::INI_UP_ALT);
    // [R12] [R13] idle unless an offered item goes out on a live link
    take_nxt = link_up_nxt && tx_offer;
    idle_nxt = !take_nxt;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      // [R26] quiet, drivers off, link down
      ini_r <= sld_pkg::INI_QUIET;
      oe_r <= '0;
      link_up_r <= 1'b0;
      wide_r <= 1'b0;
      alt_sel_r <= 1'b0;
      take_r <= 1'b0;
      idle_r <= 1'b1;
    end else begin
      ini_r <= ini_nxt;
      oe_r <= oe_nxt;
      link_up_r <= link_up_nxt;
      wide_r <= wide_nxt;
      alt_sel_r <= alt_sel_nxt;
      take_r <= take_nxt;
      idle_r <= idle_nxt;
    end
  end

  assign lane_drv_oe = oe_r;
  assign link_up = link_up_r;
  assign wide_mode = wide_r;
  assign alternate_input_select = alt_sel_r;
  assign tx_take = take_r;
  assign tx_fill_idle = idle_r;
endmodule

// ==== tb/sld_peer_model.sv ====
// far link end: lane lock flags and received marker columns
// assumes a lane only locks while our driver on that lane is enabled
`timescale 1ns/1ps
module sld_peer_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] drv_oe,
  input wire logic [3:0] want_lock,
  input wire logic col_go,
  input wire logic [3:0] col_mk,
  output logic [3:0] lane_locked,
  output sld_pkg::sld_col_t rx_col
);
  always_ff @(posedge clk) begin
    if (reset) begin
      lane_locked <= 4'h0;
      rx_col <= '0;
    end else begin
      lane_locked <= want_lock & drv_oe;
      rx_col.valid <= col_go;
      // stale markers are inverted so nothing reads them as held
      rx_col.marker <= col_go ? col_mk : ~rx_col.marker;
    end
  end
endmodule

// ==== tb/sld_link_init_checker.sv ====
// port assertions for the deskew monitor and link initializer
// assumes it is bound to every sld_link_init instance
`timescale 1ns/1ps
module sld_link_init_checker #(
  parameter int unsigned QUIET_CYCLES = 20
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] lane_locked,
  input wire logic tx_offer,
  input wire logic tx_take,
  input wire logic tx_fill_idle,
  input wire logic [3:0] lane_drv_oe,
  input wire logic link_up,
  input wire logic wide_mode,
  input wire logic alternate_input_select,
  input wire logic deskew_locked
);
  logic [31:0] quiet_r;
  logic [31:0] quiet_nxt;
  always_comb begin
    quiet_nxt = (lane_drv_oe == 4'h0) ? quiet_r + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk) begin
    quiet_r <= reset ? 32'h0 : quiet_nxt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_offer_up;
    link_up && tx_offer ##1 link_up;
  endsequence
  sequence s_down_two;
    !link_up ##1 !link_up;
  endsequence
  a_reset_quiet: assert property (disable iff (1'h0) reset |=> lane_drv_oe == 4'h0 && !link_up && tx_fill_idle)
    else $error("outputs not quiet after reset");
  a_quiet_len: assert property ($rose(lane_drv_oe[0]) |-> quiet_r >= QUIET_CYCLES && quiet_r <= QUIET_CYCLES + 3)
    else $error("quiet phase length wrong");
  a_probe_oe: assert property ($rose(lane_drv_oe[1]) |-> lane_drv_oe == 4'hF && $past(lane_drv_oe) == 4'h5)
    else $error("probe drivers wrong");
  a_wide_state: assert property (wide_mode |-> link_up && lane_drv_oe == 4'hF)
    else $error("wide mode without link up");
  a_alt_select: assert property (alternate_input_select |-> link_up && !wide_mode)
    else $error("alternate select outside single lane");
  a_deskew_drop: assert property (!(&lane_locked) |=> !deskew_locked)
    else $error("deskew held without all lanes");
  a_wide_loss: assert property (wide_mode && !deskew_locked |-> ##[1:2] !link_up)
    else $error("wide link kept after deskew loss");
  a_fill_idle: assert property (tx_fill_idle == !tx_take)
    else $error("idle fill not complement of take");
  a_idle_down: assert property (s_down_two |-> !tx_take)
    else $error("take while link down");
  a_take_offer: assert property (s_offer_up |-> tx_take)
    else $error("offer not taken while up");
endmodule
bind sld_link_init sld_link_init_checker #(.QUIET_CYCLES(QUIET_CYCLES)) u_chk (
  .clk(clk), .reset(reset), .lane_locked(lane_locked), .tx_offer(tx_offer), .tx_take(tx_take),
  .tx_fill_idle(tx_fill_idle), .lane_drv_oe(lane_drv_oe), .link_up(link_up), .wide_mode(wide_mode),
  .alternate_input_select(alternate_input_select), .deskew_locked(deskew_locked));

// ==== tb/tb.sv ====
// self-checking bench for the deskew monitor and link initializer
// assumes a four-lane build with shortened quiet and probe timers
`timescale 1ns/1ps
module tb;
  logic clk, reset, psel, penable, pwrite, tx_offer, col_go, err, o_prev, o_new;
  logic pready, pslverr, tx_take, tx_fill_idle, link_up, wide_mode, alt_sel, deskew_locked;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] lane_locked, lane_drv_oe, want_lock, col_mk;
  sld_pkg::sld_col_t rx_col;
  int failures, compares, seed, cyc, i;
  sld_link_init #(.WIDE_CAPABLE(1'b1), .QUIET_CYCLES(20), .PROBE_CYCLES(50)) u_sld_link_init (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lane_locked(lane_locked), .rx_col(rx_col), .tx_offer(tx_offer), .tx_take(tx_take),
    .tx_fill_idle(tx_fill_idle), .lane_drv_oe(lane_drv_oe), .link_up(link_up), .wide_mode(wide_mode),
    .alternate_input_select(alt_sel), .deskew_locked(deskew_locked));
  sld_peer_model u_sld_peer_model (.clk(clk), .reset(reset), .drv_oe(lane_drv_oe), .want_lock(want_lock),
    .col_go(col_go), .col_mk(col_mk), .lane_locked(lane_locked), .rx_col(rx_col));
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task summarize;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task wt(input int sel, input logic [3:0] v);
    for (int k = 0; k < 200; k++) begin
      @(posedge clk);
      #1;
      if ((sel == 0 ? lane_drv_oe : {3'h0, link_up}) === v)
        break;
    end
  endtask
  task col(input logic [3:0] m);
    @(posedge clk);
    col_go <= 1'h1;
    col_mk <= m;
    @(posedge clk);
    col_go <= 1'h0;
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [3:0] part();
    logic [3:0] m;
    m = $random(seed);
    if (m == 4'h0 || m == 4'hF)
      m = 4'h6;
    return m;
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    seed = 95118;
    {failures, compares, cyc} = 0;
    {reset, psel, penable, pwrite, tx_offer, col_go} = 6'h20;
    {paddr, pwdata, want_lock, col_mk} = '0;
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    #1;
    chk("oe_idle", 32'h1, {27'h0, lane_drv_oe, tx_fill_idle});
    apb(1'h0, 12'h004, 32'h0);
    chk("status", 32'h0001_0100, rd);
    apb(1'h0, 12'h008, 32'h0);
    chk("bad_err", 32'h1, {31'h0, err});
    chk("bad_data", 32'h0, rd);
    want_lock <= 4'hF;
    wt(0, 4'h5);
    chk("oe_search", 32'h5, {28'h0, lane_drv_oe});
    wt(0, 4'hF);
    chk("probe_down", 32'h0, {31'h0, link_up});
    settle(2);
    repeat (4) col(4'hF);
    settle(3);
    chk("confirm", 32'h0, {31'h0, deskew_locked});
    col(4'hF);
    settle(3);
    chk("wide", 32'h3, {30'h0, wide_mode, link_up});
    apb(1'h0, 12'h004, 32'h0);
    chk("status_wide", 32'h0004_101B, rd);
    o_prev = 1'h0;
    for (i = 0; i < 16; i++) begin
      o_new = $random(seed);
      @(posedge clk);
      tx_offer <= o_new;
      #1;
      chk("take", {31'h0, o_prev}, {31'h0, tx_take});
      o_prev = o_new;
    end
    col(part());
    settle(2);
    chk("recheck", 32'h1, {31'h0, deskew_locked});
    col(4'h0);
    repeat (4) col(4'hF);
    settle(1);
    apb(1'h0, 12'h004, 32'h0);
    chk("hold", 32'h4, {28'h0, rd[19:16]});
    col(part());
    col(part());
    settle(3);
    chk("dsk_lost", 32'h0, {31'h0, deskew_locked});
    want_lock <= 4'h4;
    settle(2);
    chk("wide_lost", 32'h0, {27'h0, lane_drv_oe, link_up});
    wt(1, 4'h1);
    chk("alt_up", 32'h3, {29'h0, wide_mode, alt_sel, link_up});
    want_lock <= 4'h0;
    settle(4);
    chk("alt_lost", 32'h0, {27'h0, lane_drv_oe, link_up});
    apb(1'h1, 12'h000, 32'h0000_0002);
    apb(1'h0, 12'h000, 32'h0);
    chk("ctrl", 32'h2, rd);
    want_lock <= 4'hF;
    wt(0, 4'hF);
    settle(2);
    col(4'hF);
    col(part());
    settle(1);
    apb(1'h0, 12'h004, 32'h0);
    chk("hunt", 32'h1, {28'h0, rd[19:16]});
    repeat (5) col(4'hF);
    wt(1, 4'h1);
    chk("pri_up", 32'h9, {28'h0, deskew_locked, wide_mode, alt_sel, link_up});
    apb(1'h1, 12'h000, 32'h0000_0001);
    settle(3);
    chk("restart", 32'h0, {27'h0, lane_drv_oe, link_up});
    summarize();
  end
endmodule
